// ==== logic/sfc_pkg.sv ====
// Constants shared by the flash command sequencer host
// What this block does
// - Erase starts self-timed; no preprogramming issued
// - One program sequence per byte written
// - Completion found by polling the toggle status bit
// - Write needs select low, gate high, strobe low
// - Address on later fall, data on earlier rise
package sfc_pkg;

	localparam int          ADDR_W      = 19;
	localparam int          DATA_W      = 8;
	localparam int          SECTORS     = 8;
	localparam int          SEC_W       = 3;
	localparam int          SEC_LSB     = 16;
	localparam int          REG_AW      = 3;
	localparam int          REG_DW      = 32;
	localparam int          OP_W        = 4;
	localparam int          CNT_W       = 4;
	localparam int          TMO_W       = 32;

	// Register offsets
	localparam logic [2:0]  REG_CTRL    = 3'h0;
	localparam logic [2:0]  REG_ADDR    = 3'h1;
	localparam logic [2:0]  REG_DATA    = 3'h2;
	localparam logic [2:0]  REG_SMASK   = 3'h3;
	localparam logic [2:0]  REG_STATUS  = 3'h4;
	localparam logic [2:0]  REG_RDATA   = 3'h5;

	// Status bit positions
	localparam int          ST_BUSY     = 0;
	localparam int          ST_DONE     = 1;
	localparam int          ST_FAIL     = 2;
	localparam int          ST_TOUT     = 3;

	// Operations written to the control register
	localparam logic [3:0]  OP_READ     = 4'h0;
	localparam logic [3:0]  OP_PROG     = 4'h1;
	localparam logic [3:0]  OP_SERASE   = 4'h2;
	localparam logic [3:0]  OP_CERASE   = 4'h3;
	localparam logic [3:0]  OP_SUSP     = 4'h4;
	localparam logic [3:0]  OP_RESUME   = 4'h5;
	localparam logic [3:0]  OP_ID       = 4'h6;
	localparam logic [3:0]  OP_RESET    = 4'h7;

	// Device command bytes and unlock addresses
	localparam logic [18:0] UNLOCK_A1   = 19'h00555;
	localparam logic [18:0] UNLOCK_A2   = 19'h002AA;
	localparam logic [7:0]  CMD_UNLK1   = 8'hAA;
	localparam logic [7:0]  CMD_UNLK2   = 8'h55;
	localparam logic [7:0]  CMD_PROG    = 8'hA0;
	localparam logic [7:0]  CMD_ERASE   = 8'h80;
	localparam logic [7:0]  CMD_CHIP    = 8'h10;
	localparam logic [7:0]  CMD_SECT    = 8'h30;
	localparam logic [7:0]  CMD_SUSP    = 8'hB0;
	localparam logic [7:0]  CMD_RESUME  = 8'h30;
	localparam logic [7:0]  CMD_ID      = 8'h90;
	localparam logic [7:0]  CMD_RESET   = 8'hF0;
	localparam logic [7:0]  ERASED_BYTE = 8'hFF;
	localparam int          POLL_BIT    = 7;
	localparam int          TOGGLE_BIT  = 6;

	// Timing
	localparam int          CLK_NS      = 25;
	localparam int          ACC_NS      = 55;
	localparam int          WE_NS       = 50;
	localparam int          TMO_MS      = 2000;
	localparam logic [3:0]  ACC_CYC     =
		4'((ACC_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0]  WE_CYC      =
		4'((WE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [31:0] TMO_CYC     =
		32'(TMO_MS * 1000000 / CLK_NS);

endpackage

// ==== logic/sfc_bus_cycle.sv ====
// One read or write cycle on the flash pins
`timescale 1ns/10ps
module sfc_bus_cycle (
	input  wire logic                       clk_i,
	input  wire logic                       reset_n_i,
	input  wire logic                       start_i,
	input  wire logic                       write_i,
	input  wire logic [sfc_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [sfc_pkg::DATA_W-1:0] data_i,
	output logic                            done_o,
	output logic      [sfc_pkg::DATA_W-1:0] rdata_o,
	output logic                            ce_n_o,
	output logic                            oe_n_o,
	output logic                            we_n_o,
	output logic      [sfc_pkg::ADDR_W-1:0] addr_o,
	output logic      [sfc_pkg::DATA_W-1:0] dq_o,
	output logic                            dq_oe_o,
	input  wire logic [sfc_pkg::DATA_W-1:0] dq_i
);
	import sfc_pkg::*;

	typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} sfc_cyc_t;

	sfc_cyc_t           st_q, st_d;
	logic               wr_q, wr_d;
	logic [CNT_W-1:0]   cnt_q, cnt_d;
	logic               done_d, ce_n_d, oe_n_d, we_n_d, dq_oe_d;
	logic [ADDR_W-1:0]  addr_d;
	logic [DATA_W-1:0]  dq_d, rdata_d;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_d    = st_q;
		wr_d    = wr_q;
		cnt_d   = cnt_q;
		done_d  = 1'b0;
		ce_n_d  = ce_n_o;
		oe_n_d  = oe_n_o;
		we_n_d  = we_n_o;
		dq_oe_d = dq_oe_o;
		addr_d  = addr_o;
		dq_d    = dq_o;
		rdata_d = rdata_o;
		case (st_q)
			C_IDLE: begin
				if (start_i) begin
					wr_d    = write_i;
					addr_d  = addr_i;
					dq_d    = data_i;
					ce_n_d  = 1'b0;
					oe_n_d  = 1'b1;
					we_n_d  = 1'b1;
					dq_oe_d = write_i;
					st_d    = C_SETUP;
				end
			end
			C_SETUP: begin
				if (wr_q) begin
					we_n_d = 1'b0;
					cnt_d  = WE_CYC - 4'h1;
				end else begin
					oe_n_d = 1'b0;
					cnt_d  = ACC_CYC - 4'h1;
				end
				st_d = C_STROBE;
			end
			C_STROBE: begin
				if (cnt_q == '0) begin
					if (wr_q) begin
						we_n_d = 1'b1;
					end else begin
						rdata_d = dq_i;
						oe_n_d  = 1'b1;
					end
					st_d = C_HOLD;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			C_HOLD: begin
				ce_n_d  = 1'b1;
				dq_oe_d = 1'b0;
				done_d  = 1'b1;
				st_d    = C_IDLE;
			end
			default: begin
				st_d = C_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			st_q    <= C_IDLE;
			wr_q    <= 1'b0;
			cnt_q   <= '0;
			done_o  <= 1'b0;
			ce_n_o  <= 1'b1;
			oe_n_o  <= 1'b1;
			we_n_o  <= 1'b1;
			dq_oe_o <= 1'b0;
			addr_o  <= '0;
			dq_o    <= '0;
			rdata_o <= '0;
		end else begin
			st_q    <= st_d;
			wr_q    <= wr_d;
			cnt_q   <= cnt_d;
			done_o  <= done_d;
			ce_n_o  <= ce_n_d;
			oe_n_o  <= oe_n_d;
			we_n_o  <= we_n_d;
			dq_oe_o <= dq_oe_d;
			addr_o  <= addr_d;
			dq_o    <= dq_d;
			rdata_o <= rdata_d;
		end
	end

endmodule

// ==== logic/sfc_host.sv ====
// Flash command sequencer host with software register port
`timescale 1ns/10ps
module sfc_host #(
	parameter logic [31:0] POLL_LIMIT = sfc_pkg::TMO_CYC
) (
	input  wire logic                       clk_i,
	input  wire logic                       reset_n_i,
	input  wire logic [sfc_pkg::REG_AW-1:0] reg_addr_i,
	input  wire logic [sfc_pkg::REG_DW-1:0] reg_wdata_i,
	input  wire logic                       reg_wr_i,
	input  wire logic                       reg_rd_i,
	output logic      [sfc_pkg::REG_DW-1:0] reg_rdata_o,
	output logic                            flash_ce_n_o,
	output logic                            flash_oe_n_o,
	output logic                            flash_we_n_o,
	output logic      [sfc_pkg::ADDR_W-1:0] byte_address_lines_o,
	output logic      [sfc_pkg::DATA_W-1:0] byte_data_lines_o,
	output logic                            byte_data_lines_oe_o,
	input  wire logic [sfc_pkg::DATA_W-1:0] byte_data_lines_i
);
	import sfc_pkg::*;

	typedef enum logic [1:0] {S_IDLE, S_CMD, S_RD, S_POLL} sfc_state_t;

	////////////////////////////////////////////////////////////////////////
	// Sequence helpers

	function automatic logic [ADDR_W-1:0] sec_base(input logic [2:0] s);
		sec_base = {s, 16'h0000};
	endfunction

	function automatic logic [2:0] low_bit(input logic [SECTORS-1:0] m);
		low_bit = 3'h0;
		for (int i = SECTORS - 1; i >= 0; i--) begin
			if (m[i]) begin
				low_bit = 3'(i);
			end
		end
	endfunction

	function automatic logic [ADDR_W+DATA_W-1:0] seq_word(
		input logic [OP_W-1:0]   op,
		input logic [2:0]        step,
		input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d,
		input logic [2:0]        s
	);
		seq_word = {UNLOCK_A1, CMD_UNLK1};
		case (op)
			OP_SUSP:   seq_word = {a, CMD_SUSP};
			OP_RESUME: seq_word = {a, CMD_RESUME};
			OP_RESET:  seq_word = {a, CMD_RESET};
			default: begin
				case (step)
					3'h1: seq_word = {UNLOCK_A2, CMD_UNLK2};
					3'h2: begin
						if (op == OP_PROG) begin
							seq_word = {UNLOCK_A1, CMD_PROG};
						end else if (op == OP_ID) begin
							seq_word = {UNLOCK_A1, CMD_ID};
						end else begin
							seq_word = {UNLOCK_A1, CMD_ERASE};
						end
					end
					3'h3: begin
						if (op == OP_PROG) begin
							seq_word = {a, d};
						end
					end
					3'h4: seq_word = {UNLOCK_A2, CMD_UNLK2};
					3'h5: begin
						if (op == OP_CERASE) begin
							seq_word = {UNLOCK_A1, CMD_CHIP};
						end else begin
							seq_word = {sec_base(s), CMD_SECT};
						end
					end
					default: seq_word = {UNLOCK_A1, CMD_UNLK1};
				endcase
			end
		endcase
	endfunction

	function automatic logic seq_last(
		input logic [OP_W-1:0] op,
		input logic [2:0]      step
	);
		case (op)
			OP_PROG:   seq_last = (step == 3'h3);
			OP_ID:     seq_last = (step == 3'h2);
			OP_CERASE: seq_last = (step == 3'h5);
			OP_SERASE: seq_last = (step == 3'h5);
			default:   seq_last = 1'b1;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	sfc_state_t          st_q, st_d;
	logic [OP_W-1:0]     op_q, op_d;
	logic [2:0]          step_q, step_d;
	logic [ADDR_W-1:0]   addr_q, addr_d;
	logic [DATA_W-1:0]   data_q, data_d;
	logic [SECTORS-1:0]  smask_q, smask_d;
	logic [SECTORS-1:0]  mask_q, mask_d;
	logic [2:0]          sec_q, sec_d;
	logic [DATA_W-1:0]   prev_q, prev_d;
	logic                have_q, have_d;
	logic                susp_q, susp_d;
	logic [TMO_W-1:0]    tmo_q, tmo_d;
	logic                done_q, done_d;
	logic                fail_q, fail_d;
	logic                tout_q, tout_d;
	logic [DATA_W-1:0]   rd_q, rd_d;
	logic [REG_DW-1:0]   rdata_d;
	logic                cs_q, cs_d;
	logic                cw_q, cw_d;
	logic [ADDR_W-1:0]   ca_q, ca_d;
	logic [DATA_W-1:0]   cd_q, cd_d;
	logic                cyc_done;
	logic [DATA_W-1:0]   cyc_rdata;
	logic [SECTORS-1:0]  rest;
	logic [DATA_W-1:0]   expect_b;

	////////////////////////////////////////////////////////////////////////
	// Sequencer and register port

	always_comb begin
		st_d    = st_q;
		op_d    = op_q;
		step_d  = step_q;
		addr_d  = addr_q;
		data_d  = data_q;
		smask_d = smask_q;
		mask_d  = mask_q;
		sec_d   = sec_q;
		prev_d  = prev_q;
		have_d  = have_q;
		susp_d  = susp_q;
		tmo_d   = tmo_q;
		done_d  = done_q;
		fail_d  = fail_q;
		tout_d  = tout_q;
		rd_d    = rd_q;
		cs_d    = 1'b0;
		cw_d    = cw_q;
		ca_d    = ca_q;
		cd_d    = cd_q;
		rdata_d = '0;
		rest    = mask_q & ~(8'h01 << sec_q);
		expect_b = (op_q == OP_PROG) ? data_q : ERASED_BYTE;
		if (reg_rd_i) begin
			case (reg_addr_i)
				REG_ADDR:   rdata_d = {13'h0000, addr_q};
				REG_DATA:   rdata_d = {24'h000000, data_q};
				REG_SMASK:  rdata_d = {24'h000000, smask_q};
				REG_STATUS: rdata_d = {28'h0000000, tout_q, fail_q, done_q,
					st_q != S_IDLE};
				REG_RDATA:  rdata_d = {24'h000000, rd_q};
				default:    rdata_d = '0;
			endcase
		end
		case (st_q)
			S_IDLE: begin
				if (reg_wr_i && reg_addr_i == REG_ADDR) begin
					addr_d = reg_wdata_i[ADDR_W-1:0];
				end
				if (reg_wr_i && reg_addr_i == REG_DATA) begin
					data_d = reg_wdata_i[DATA_W-1:0];
				end
				if (reg_wr_i && reg_addr_i == REG_SMASK) begin
					smask_d = reg_wdata_i[SECTORS-1:0];
				end
				if (reg_wr_i && reg_addr_i == REG_CTRL) begin
					op_d   = reg_wdata_i[OP_W-1:0];
					step_d = 3'h0;
					mask_d = smask_q;
					sec_d  = low_bit(smask_q);
					done_d = 1'b0;
					fail_d = 1'b0;
					tout_d = 1'b0;
					susp_d = 1'b0;
					cs_d   = 1'b1;
					ca_d   = addr_q;
					if (reg_wdata_i[OP_W-1:0] == OP_READ) begin
						cw_d = 1'b0;
						st_d = S_RD;
					end else if (reg_wdata_i[OP_W-1:0] == OP_SERASE &&
						smask_q == '0) begin
						cs_d   = 1'b0;
						done_d = 1'b1;
						fail_d = 1'b1;
					end else begin
						cw_d = 1'b1;
						{ca_d, cd_d} = seq_word(reg_wdata_i[OP_W-1:0],
							3'h0, addr_q, data_q, 3'h0);
						st_d = S_CMD;
					end
				end
			end
			S_CMD: begin
				if (cyc_done) begin
					cs_d = 1'b1;
					if (op_q == OP_SERASE && step_q == 3'h5 && rest != '0) begin
						mask_d = rest;
						sec_d  = low_bit(rest);
						cw_d   = 1'b1;
						{ca_d, cd_d} = seq_word(op_q, step_q, addr_q, data_q,
							low_bit(rest));
					end else if (!seq_last(op_q, step_q)) begin
						step_d = step_q + 3'h1;
						cw_d   = 1'b1;
						{ca_d, cd_d} = seq_word(op_q, step_q + 3'h1, addr_q,
							data_q, sec_q);
					end else if (op_q == OP_PROG || op_q == OP_SERASE ||
						op_q == OP_CERASE) begin
						cw_d   = 1'b0;
						ca_d   = (op_q == OP_PROG) ? addr_q : sec_base(sec_q);
						have_d = 1'b0;
						tmo_d  = '0;
						st_d   = S_POLL;
					end else if (op_q == OP_ID) begin
						cw_d = 1'b0;
						ca_d = addr_q;
						st_d = S_RD;
					end else begin
						cs_d   = 1'b0;
						done_d = 1'b1;
						st_d   = S_IDLE;
					end
				end
			end
			S_RD: begin
				if (cyc_done) begin
					rd_d   = cyc_rdata;
					done_d = 1'b1;
					st_d   = S_IDLE;
				end
			end
			S_POLL: begin
				tmo_d = tmo_q + 32'h00000001;
				if (reg_wr_i && reg_addr_i == REG_CTRL &&
					reg_wdata_i[OP_W-1:0] == OP_SUSP && op_q != OP_PROG) begin
					susp_d = 1'b1;
				end
				if (tmo_q == POLL_LIMIT) begin
					tout_d = 1'b1;
					fail_d = 1'b1;
					done_d = 1'b1;
					st_d   = S_IDLE;
				end else if (cyc_done) begin
					if (susp_q) begin
						op_d   = OP_SUSP;
						step_d = 3'h0;
						cs_d   = 1'b1;
						cw_d   = 1'b1;
						{ca_d, cd_d} = seq_word(OP_SUSP, 3'h0, addr_q, data_q,
							3'h0);
						st_d   = S_CMD;
					end else if (have_q &&
						cyc_rdata[TOGGLE_BIT] == prev_q[TOGGLE_BIT]) begin
						rd_d   = cyc_rdata;
						fail_d = (cyc_rdata != expect_b) ||
							(cyc_rdata[POLL_BIT] != expect_b[POLL_BIT]);
						done_d = 1'b1;
						st_d   = S_IDLE;
					end else begin
						prev_d = cyc_rdata;
						have_d = 1'b1;
						cs_d   = 1'b1;
						cw_d   = 1'b0;
					end
				end
			end
			default: begin
				st_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			st_q        <= S_IDLE;
			op_q        <= OP_READ;
			step_q      <= 3'h0;
			addr_q      <= '0;
			data_q      <= '0;
			smask_q     <= '0;
			mask_q      <= '0;
			sec_q       <= 3'h0;
			prev_q      <= '0;
			have_q      <= 1'b0;
			susp_q      <= 1'b0;
			tmo_q       <= '0;
			done_q      <= 1'b0;
			fail_q      <= 1'b0;
			tout_q      <= 1'b0;
			rd_q        <= '0;
			cs_q        <= 1'b0;
			cw_q        <= 1'b0;
			ca_q        <= '0;
			cd_q        <= '0;
			reg_rdata_o <= '0;
		end else begin
			st_q        <= st_d;
			op_q        <= op_d;
			step_q      <= step_d;
			addr_q      <= addr_d;
			data_q      <= data_d;
			smask_q     <= smask_d;
			mask_q      <= mask_d;
			sec_q       <= sec_d;
			prev_q      <= prev_d;
			have_q      <= have_d;
			susp_q      <= susp_d;
			tmo_q       <= tmo_d;
			done_q      <= done_d;
			fail_q      <= fail_d;
			tout_q      <= tout_d;
			rd_q        <= rd_d;
			cs_q        <= cs_d;
			cw_q        <= cw_d;
			ca_q        <= ca_d;
			cd_q        <= cd_d;
			reg_rdata_o <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin cycle engine

	sfc_bus_cycle u_cycle (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.start_i   (cs_q),
		.write_i   (cw_q),
		.addr_i    (ca_q),
		.data_i    (cd_q),
		.done_o    (cyc_done),
		.rdata_o   (cyc_rdata),
		.ce_n_o    (flash_ce_n_o),
		.oe_n_o    (flash_oe_n_o),
		.we_n_o    (flash_we_n_o),
		.addr_o    (byte_address_lines_o),
		.dq_o      (byte_data_lines_o),
		.dq_oe_o   (byte_data_lines_oe_o),
		.dq_i      (byte_data_lines_i)
	);

endmodule

// ==== tb/sfc_host_monitor.sv ====
// Pin checks for the flash command sequencer host
`timescale 1ns/10ps
module sfc_host_monitor (
	input  wire logic                       clk_i,
	input  wire logic                       reset_n_i,
	input  wire logic                       flash_ce_n_o,
	input  wire logic                       flash_oe_n_o,
	input  wire logic                       flash_we_n_o,
	input  wire logic [sfc_pkg::ADDR_W-1:0] byte_address_lines_o,
	input  wire logic [sfc_pkg::DATA_W-1:0] byte_data_lines_o,
	input  wire logic                       byte_data_lines_oe_o
);
	import sfc_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	////////////////////////////////////////////////////////////////////////
	property p_wr_gate; !flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o;
	endproperty
	a_wr_gate: assert property (p_wr_gate) else $error("bad write");
	property p_rd_gate; !flash_oe_n_o |->
		!flash_ce_n_o && flash_we_n_o && !byte_data_lines_oe_o; endproperty
	a_rd_gate: assert property (p_rd_gate) else $error("bad read");
	property p_idle; flash_ce_n_o |->
		flash_oe_n_o && flash_we_n_o && !byte_data_lines_oe_o; endproperty
	a_idle: assert property (p_idle) else $error("pins active idle");
	property p_we_len; $fell(flash_we_n_o) |=>
		!flash_we_n_o ##1 flash_we_n_o; endproperty
	a_we_len: assert property (p_we_len) else $error("strobe width");
	property p_wr_hold; !flash_we_n_o |-> byte_data_lines_oe_o &&
		$stable(byte_address_lines_o) && $stable(byte_data_lines_o);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write moved");
	property p_wr_end; $rose(flash_we_n_o) |=>
		$rose(flash_ce_n_o) && !byte_data_lines_oe_o; endproperty
	a_wr_end: assert property (p_wr_end) else $error("write end");
	property p_rd_len; $fell(flash_oe_n_o) |-> !flash_oe_n_o [*3]
		##1 flash_oe_n_o ##1 $rose(flash_ce_n_o); endproperty
	a_rd_len: assert property (p_rd_len) else $error("read width");
	property p_gap; $rose(flash_ce_n_o) |=> flash_ce_n_o; endproperty
	a_gap: assert property (p_gap) else $error("no idle cycle");
	property p_setup; $fell(flash_ce_n_o) |-> flash_we_n_o && flash_oe_n_o;
	endproperty
	a_setup: assert property (p_setup) else $error("select late");
endmodule

// ==== tb/sfc_flash_model.sv ====
// Behavioural model of the byte-wide flash device
`timescale 1ns/10ps
module sfc_flash_model #(
	parameter int         BUSY   = 150,
	parameter logic [7:0] MFR_ID = 8'h3C, // Arbitrary value
	parameter logic [7:0] DEV_ID = 8'hC5  // Arbitrary value
) (
	input  wire logic                        clk_i,
	input  wire logic                        ce_n_i,
	input  wire logic                        oe_n_i,
	input  wire logic                        we_n_i,
	input  wire logic [sfc_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [sfc_pkg::DATA_W-1:0]  dq_i,
	input  wire logic [sfc_pkg::SECTORS-1:0] prot_i,
	input  wire logic                        low_vcc_i,
	output logic      [sfc_pkg::DATA_W-1:0]  dq_o
);
	import sfc_pkg::*;
	logic [DATA_W-1:0]  mem [2**ADDR_W];
	logic [ADDR_W-1:0]  la, pa;
	logic [DATA_W-1:0]  pd, last, rv;
	logic [SECTORS-1:0] em;
	logic               busy, susp, ers, idm, tog, drv;
	int                 st, cnt;
	initial begin
		foreach (mem[i]) mem[i] = ERASED_BYTE;
		{busy, susp, ers, idm, tog, last, em, st, cnt} = '0;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic cmd(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		if (busy && !susp) begin
			if (d == CMD_SUSP && ers) begin
				susp = 1;
				st = 0;
			end else if (st == 7 && d == CMD_SECT) em[a[SEC_LSB+:SEC_W]] = 1;
		end else if (susp && d == CMD_RESUME) susp = 0;
		else if (d == CMD_RESET) begin
			st = 0;
			idm = 0;
		end else case (st)
			0, 3: st = (a == UNLOCK_A1 && d == CMD_UNLK1) ? st + 1 : 0;
			1, 4: st = (a == UNLOCK_A2 && d == CMD_UNLK2) ? st + 1 : 0;
			2: begin
				idm = (a == UNLOCK_A1 && d == CMD_ID);
				st = a != UNLOCK_A1 ? 0 : d == CMD_PROG ? 6 : d == CMD_ERASE ? 3 : 0;
			end
			5: begin
				st = (d == CMD_SECT) ? 7 : 0;
				if (a == UNLOCK_A1 && d == CMD_CHIP) em = '1;
				if (d == CMD_SECT) em[a[SEC_LSB+:SEC_W]] = 1;
				ers = 1;
				busy = (em != 0);
				cnt = BUSY;
			end
			6: begin
				pa = a;
				pd = d;
				{ers, busy, st, cnt} = {1'b0, 1'b1, 32'd0, BUSY};
			end
			default: st = 0;
		endcase
	endtask
	always @(negedge we_n_i or negedge ce_n_i)
		if (!we_n_i && !ce_n_i) la = addr_i;
	always @(posedge we_n_i or posedge ce_n_i)
		if (we_n_i != ce_n_i && oe_n_i && !low_vcc_i) cmd(la, dq_i);
	always @(posedge clk_i)
		if (busy && !susp) begin
			if (cnt > 0) cnt--;
			else begin
				if (ers) begin
					for (int i = 0; i < 2**ADDR_W; i++)
						if (em[i >> SEC_LSB] && !prot_i[i >> SEC_LSB]) mem[i] = ERASED_BYTE;
				end else if (!prot_i[pa[SEC_LSB+:SEC_W]]) mem[pa] = pd;
				{busy, em, st} = '0;
			end
		end
	always @(negedge oe_n_i) if (busy && !susp) tog = ~tog;
	assign drv = !ce_n_i && !oe_n_i && we_n_i;
	assign rv = (busy && !susp) ? {~ers & ~pd[POLL_BIT], tog, 6'h00} :
		idm ? (addr_i[0] ? DEV_ID : MFR_ID) : mem[addr_i];
	assign dq_o = drv ? rv : ~last;
	always @(posedge clk_i) if (drv) last <= rv;
endmodule

// ==== tb/sfc_host_tb.sv ====
// Self-checking bench for the flash command sequencer host
`timescale 1ns/10ps
module sfc_host_tb;
	import sfc_pkg::*;
	logic               clk_i, reset_n_i, reg_wr_i, reg_rd_i, low_vcc;
	logic [REG_AW-1:0]  reg_addr_i;
	logic [REG_DW-1:0]  reg_wdata_i, reg_rdata_o, q;
	logic               flash_ce_n_o, flash_oe_n_o, flash_we_n_o;
	logic               byte_data_lines_oe_o;
	logic [ADDR_W-1:0]  byte_address_lines_o;
	logic [DATA_W-1:0]  byte_data_lines_o, dev_q, dq;
	logic [SECTORS-1:0] prot;
	int                 errors, check_count;
	logic [ADDR_W-1:0]  ta [5] = '{19'h12345, 19'h12346, 19'h20010,
		19'h30020, 19'h60000};
	logic [DATA_W-1:0]  td [5] = '{8'h5A, 8'hA5, 8'h3C, 8'h96, 8'hC3};
	assign dq = byte_data_lines_oe_o ? byte_data_lines_o : dev_q;
	sfc_host #(.POLL_LIMIT(32'h190)) u_sfc_host (
		.clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o,
		.byte_address_lines_o, .byte_data_lines_o, .byte_data_lines_oe_o,
		.byte_data_lines_i(dq));
	sfc_flash_model u_sfc_flash_model (.clk_i, .ce_n_i(flash_ce_n_o),
		.oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o),
		.addr_i(byte_address_lines_o), .dq_i(dq), .prot_i(prot),
		.low_vcc_i(low_vcc), .dq_o(dev_q));
	initial begin
		clk_i = 0;
		forever #12.5 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 q = reg_rdata_o;
	endtask
	task automatic op(input logic [OP_W-1:0] o);
		wr(REG_CTRL, {28'h0, o});
		for (int i = 0; i < 600; i++) begin
			rd(REG_STATUS);
			if (q[ST_BUSY] === 1'b0) break;
		end
		chk("op finished", 32'h0, {31'h0, q[ST_BUSY]});
	endtask
	task automatic prog(input logic [18:0] a, input logic [7:0] d);
		wr(REG_ADDR, {13'h0, a});
		wr(REG_DATA, {24'h0, d});
		op(OP_PROG);
	endtask
	task automatic byte_at(input logic [18:0] a, input logic [7:0] e);
		wr(REG_ADDR, {13'h0, a});
		op(OP_READ);
		rd(REG_RDATA);
		chk("array byte", {24'h0, e}, q);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#(25 * 60000);
		errors++;
		final_report();
	end
	initial begin
		{reset_n_i, reg_wr_i, reg_rd_i, low_vcc, prot} = '0;
		{reg_addr_i, reg_wdata_i, errors, check_count} = '0;
		repeat (6) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rd(REG_STATUS);
		chk("status after reset", 32'h0, q);
		rd(3'h6);
		chk("unmapped", 32'h0, q);
		foreach (ta[i]) begin
			prog(ta[i], td[i]);
			chk("program status", 32'h2, q);
		end
		foreach (ta[i]) byte_at(ta[i], td[i]);
		rd(REG_DATA);
		chk("data register", 32'hC3, q);
		prot <= 8'h40;
		prog(19'h60001, 8'h11);
		chk("protected status", 32'h6, q);
		byte_at(19'h60001, 8'hFF);
		low_vcc <= 1'b1;
		prog(19'h20011, 8'h22);
		chk("low supply status", 32'h6, q);
		low_vcc <= 1'b0;
		byte_at(19'h20011, 8'hFF);
		wr(REG_SMASK, 32'h0);
		op(OP_SERASE);
		chk("empty mask status", 32'h6, q);
		wr(REG_SMASK, 32'h3);
		wr(REG_ADDR, 32'h10000);
		op(OP_SERASE);
		chk("erase status", 32'h2, q);
		byte_at(19'h12345, 8'hFF);
		byte_at(19'h20010, 8'h3C);
		wr(REG_SMASK, 32'h8);
		rd(REG_SMASK);
		chk("smask register", 32'h8, q);
		wr(REG_ADDR, 32'h30000);
		rd(REG_ADDR);
		chk("addr register", 32'h30000, q);
		wr(REG_CTRL, {28'h0, OP_SERASE});
		rd(REG_STATUS);
		chk("busy status", 32'h1, q);
		for (int i = 0; i < 300 && flash_oe_n_o !== 1'b0; i++) @(posedge clk_i);
		chk("poll started", 32'h0, {31'h0, flash_oe_n_o});
		op(OP_SUSP);
		chk("suspend status", 32'h2, q);
		byte_at(19'h20010, 8'h3C);
		wr(REG_ADDR, 32'h30000);
		op(OP_RESUME);
		chk("resume status", 32'h2, q);
		// Resume does not poll; let the resumed erase run out
		repeat (200) @(posedge clk_i);
		byte_at(19'h30020, 8'hFF);
		for (int i = 0; i < 2; i++) begin
			wr(REG_ADDR, i);
			op(OP_ID);
			rd(REG_RDATA);
			chk("id byte", i ? 32'hC5 : 32'h3C, q);
		end
		op(OP_RESET);
		byte_at(19'h20010, 8'h3C);
		wr(REG_ADDR, 32'h0);
		op(OP_CERASE);
		chk("chip erase status", 32'h2, q);
		byte_at(19'h20010, 8'hFF);
		byte_at(19'h60000, 8'hC3);
		final_report();
	end
endmodule
bind sfc_host sfc_host_monitor u_sfc_host_monitor (.clk_i, .reset_n_i,
	.flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .byte_address_lines_o,
	.byte_data_lines_o, .byte_data_lines_oe_o);
